//--- core/lss_fsm.sv
`timescale 1ns/1ps
`include "lss_params.svh"
module lss_fsm (
    input wire logic clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic link_lost,
    input wire logic l1_sync_ok,
    input wire logic ver_done,
    input wire logic mgmt_done,
    input wire logic mgmt_fail,
    input wire logic vend_done,
    output lss_pkg::lss_code_t code
);
    import lss_pkg::*;
    lss_state_t state; // current start-up state
    lss_state_t next_state; // state for the next edge
    ////////////////////////////////////////////////////////////////
    // transition choice
    always_comb begin
        next_state = state;
        unique case (state)
            LSS_STANDBY: if (start) next_state = LSS_L1SYNC;
            LSS_L1SYNC: if (l1_sync_ok) next_state = LSS_PROTO;
            LSS_PROTO: if (ver_done) next_state = LSS_MGMT;
            LSS_MGMT: begin
                if (mgmt_done) begin
                    next_state = LSS_IFACE;
                end else if (mgmt_fail) begin
                    next_state = LSS_PASSIVE;
                end
            end
            LSS_IFACE: if (vend_done) next_state = LSS_OPER;
            LSS_OPER: next_state = LSS_OPER;
            LSS_PASSIVE: next_state = LSS_PASSIVE;
        endcase
        // loss of link drops back to standby
        if (link_lost) next_state = LSS_STANDBY;
    end
    // state register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= LSS_STANDBY;
        end else begin
            state <= next_state;
        end
    end
    // code register seen by software, from the same next value
    always_ff @(posedge clk) begin
        if (!resetn) begin
            code <= `LSS_CODE_STANDBY;
        end else begin
            unique case (next_state)
                LSS_STANDBY: code <= `LSS_CODE_STANDBY;
                LSS_L1SYNC: code <= `LSS_CODE_L1SYNC;
                LSS_PROTO: code <= `LSS_CODE_PROTO;
                LSS_MGMT: code <= `LSS_CODE_MGMT;
                LSS_IFACE: code <= `LSS_CODE_IFACE;
                LSS_OPER: code <= `LSS_CODE_OPER;
                LSS_PASSIVE: code <= `LSS_CODE_PASSIVE;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////
    a_vendor_gate: assert property (@(posedge clk)
        disable iff (!resetn) state == LSS_IFACE && !vend_done
        |=> state != LSS_OPER)
        else $error("operation entered without vendor done");
    a_mgmt_fail: assert property (@(posedge clk)
        disable iff (!resetn) state == LSS_MGMT && mgmt_fail && !mgmt_done
        && !link_lost |=> code == `LSS_CODE_PASSIVE)
        else $error("failed negotiation did not reach passive");
    a_proto_gate: assert property (@(posedge clk)
        disable iff (!resetn) state == LSS_PROTO && !ver_done
        |=> state != LSS_MGMT)
        else $error("management setup entered too early");
endmodule // lss_fsm

//--- core/lss_params.svh
`ifndef LSS_PARAMS_SVH
`define LSS_PARAMS_SVH
// register byte offsets
`define LSS_OFF_MGMT_CFG 8'h1C
`define LSS_OFF_STATUS 8'h24
`define LSS_OFF_TIMER 8'h28
`define LSS_OFF_VER_CFG 8'h38
`define LSS_OFF_IRQ_STAT 8'h3C
`define LSS_OFF_IRQ_MASK 8'h40
// status register fields
`define LSS_BIT_LINE_DONE 0
`define LSS_BIT_VER_DONE 1
`define LSS_BIT_MGMT_DONE 2
`define LSS_BIT_VEND_DONE 3
`define LSS_POS_STATE 8
`define LSS_BIT_EXPIRED 16
// configuration fields
`define LSS_BIT_ETH_AUTO 7
`define LSS_BIT_HDLC_AUTO 12
`define LSS_BIT_VER_AUTO 0
// interrupt status fields
`define LSS_IRQ_EXPIRED 0
`define LSS_IRQ_OPER 1
`define LSS_IRQ_PASSIVE 2
// reset values
`define LSS_RST_DONE 4'h0
`define LSS_RST_LIMIT 20'h00000
`define LSS_RST_HDLC_AUTO 1'b1
`define LSS_RST_ETH_AUTO 1'b1
`define LSS_RST_VER_AUTO 1'b0
// state codes as software sees them
`define LSS_CODE_STANDBY 3'h0
`define LSS_CODE_L1SYNC 3'h1
`define LSS_CODE_PROTO 3'h3
`define LSS_CODE_MGMT 3'h2
`define LSS_CODE_IFACE 3'h6
`define LSS_CODE_OPER 3'h7
`define LSS_CODE_PASSIVE 3'h5
`endif

//--- core/lss_pkg.sv
package lss_pkg;
    // start-up sequence states
    typedef enum logic [2:0] {
        LSS_STANDBY,
        LSS_L1SYNC,
        LSS_PROTO,
        LSS_MGMT,
        LSS_IFACE,
        LSS_OPER,
        LSS_PASSIVE
    } lss_state_t;
    // state code as shown in the status register
    typedef logic [2:0] lss_code_t;
endpackage

//--- core/lss_regs.sv
//////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "lss_params.svh"
module lss_regs #(
    parameter bit SM_EN = 1'b1,
    parameter int LIMIT_W = 20
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq,
    input wire logic start,
    input wire logic link_lost,
    input wire logic l1_sync_ok,
    input wire logic line_done_in,
    input wire logic ver_done_in,
    input wire logic mgmt_done_in,
    input wire logic vend_done_in,
    input wire logic ver_auto_ok,
    input wire logic mgmt_auto_ok,
    input wire logic mgmt_auto_fail,
    output lss_pkg::lss_code_t state_code,
    output logic timer_expired
);
    import lss_pkg::*;
    //////////////////////////////////////////////////////////////////
    // storage
    logic [3:0] done; // negotiation done bits
    logic [LIMIT_W-1:0] limit; // timer threshold
    logic hdlc_auto; // hdlc rate autoneg enable
    logic eth_auto; // ethernet pointer autoneg enable
    logic ver_auto; // version autoneg enable
    logic [2:0] irq_stat; // sticky event bits
    logic [2:0] irq_mask; // event enables
    lss_code_t code; // state code from machine
    logic expired; // timer expiry from timer
    logic expired_d; // expiry one cycle back
    lss_code_t code_d; // code one cycle back
    logic [31:0] next_rdata; // read mux result
    //////////////////////////////////////////////////////////////////
    // decode
    logic wr_stat; // write to status register
    logic wr_tim; // write to timer register
    logic wr_mcfg; // write to management config
    logic wr_vcfg; // write to version config
    logic wr_istat; // write to interrupt status
    logic wr_imask; // write to interrupt mask
    assign wr_stat = wr && addr == `LSS_OFF_STATUS && SM_EN;
    assign wr_tim = wr && addr == `LSS_OFF_TIMER && SM_EN;
    assign wr_mcfg = wr && addr == `LSS_OFF_MGMT_CFG;
    assign wr_vcfg = wr && addr == `LSS_OFF_VER_CFG;
    assign wr_istat = wr && addr == `LSS_OFF_IRQ_STAT;
    assign wr_imask = wr && addr == `LSS_OFF_IRQ_MASK;
    //////////////////////////////////////////////////////////////////
    // hardware set terms per done bit
    logic [3:0] hw_set; // set requests, win over software
    logic mgmt_auto; // any management autoneg enabled
    assign mgmt_auto = hdlc_auto || eth_auto;
    always_comb begin
        hw_set = 4'h0;
        if (SM_EN) begin
            // inputs write their bits directly
            hw_set[`LSS_BIT_LINE_DONE] = line_done_in;
            hw_set[`LSS_BIT_VER_DONE] = ver_done_in
                || (ver_auto && ver_auto_ok);
            hw_set[`LSS_BIT_MGMT_DONE] = mgmt_done_in
                || (mgmt_auto && mgmt_auto_ok);
            hw_set[`LSS_BIT_VEND_DONE] = vend_done_in;
        end
    end
    // done bits, one per loop entry
    localparam logic [3:0] RST_DONE = `LSS_RST_DONE; // reset value per bit
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_done
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    done[gi] <= RST_DONE[gi];
                end else if (hw_set[gi]) begin
                    done[gi] <= 1'b1;
                end else if (wr_stat) begin
                    done[gi] <= wdata[gi];
                end
            end
        end
    endgenerate
    //////////////////////////////////////////////////////////////////
    // timer threshold
    always_ff @(posedge clk) begin
        if (!resetn) begin
            limit <= `LSS_RST_LIMIT;
        end else if (wr_tim) begin
            limit <= wdata[LIMIT_W-1:0];
        end
    end
    // management channel autoneg enables
    always_ff @(posedge clk) begin
        if (!resetn) begin
            hdlc_auto <= `LSS_RST_HDLC_AUTO;
            eth_auto <= `LSS_RST_ETH_AUTO;
        end else if (wr_mcfg) begin
            hdlc_auto <= wdata[`LSS_BIT_HDLC_AUTO];
            eth_auto <= wdata[`LSS_BIT_ETH_AUTO];
        end
    end
    // version autoneg enable
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ver_auto <= `LSS_RST_VER_AUTO;
        end else if (wr_vcfg) begin
            ver_auto <= wdata[`LSS_BIT_VER_AUTO];
        end
    end
    //////////////////////////////////////////////////////////////////
    // start-up machine, held in standby when not built
    lss_fsm u_fsm (
        .clk(clk),
        .resetn(resetn),
        .start(start && SM_EN),
        .link_lost(link_lost),
        .l1_sync_ok(l1_sync_ok),
        .ver_done(done[`LSS_BIT_VER_DONE]),
        .mgmt_done(done[`LSS_BIT_MGMT_DONE]),
        .mgmt_fail(mgmt_auto_fail),
        .vend_done(done[`LSS_BIT_VEND_DONE]),
        .code(code)
    );
    assign state_code = code;
    // timer runs outside standby and operation
    logic timer_run; // timer counting
    assign timer_run = code != `LSS_CODE_STANDBY
        && code != `LSS_CODE_OPER;
    lss_timer #(
        .WIDTH(LIMIT_W)
    ) u_timer (
        .clk(clk),
        .resetn(resetn),
        .run(timer_run),
        .limit(limit),
        .expired(expired)
    );
    assign timer_expired = expired;
    //////////////////////////////////////////////////////////////////
    // edge history for interrupt events
    always_ff @(posedge clk) begin
        if (!resetn) begin
            expired_d <= 1'b0;
            code_d <= `LSS_CODE_STANDBY;
        end else begin
            expired_d <= expired;
            code_d <= code;
        end
    end
    logic [2:0] ev; // one-cycle events
    assign ev[`LSS_IRQ_EXPIRED] = expired && !expired_d;
    assign ev[`LSS_IRQ_OPER] = code == `LSS_CODE_OPER
        && code_d != `LSS_CODE_OPER;
    assign ev[`LSS_IRQ_PASSIVE] = code == `LSS_CODE_PASSIVE
        && code_d != `LSS_CODE_PASSIVE;
    // sticky status, set wins over write-one-clear
    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq_stat <= 3'h0;
        end else if (wr_istat) begin
            irq_stat <= (irq_stat & ~wdata[2:0]) | ev;
        end else begin
            irq_stat <= irq_stat | ev;
        end
    end
    // mask register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq_mask <= 3'h0;
        end else if (wr_imask) begin
            irq_mask <= wdata[2:0];
        end
    end
    // interrupt level from flop
    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end
    //////////////////////////////////////////////////////////////////
    // read mux, reserved bits zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (addr)
            `LSS_OFF_STATUS: begin
                if (SM_EN) begin
                    next_rdata[3:0] = done;
                    next_rdata[`LSS_POS_STATE +: 3] = code;
                    next_rdata[`LSS_BIT_EXPIRED] = expired;
                end
            end
            `LSS_OFF_TIMER: begin
                if (SM_EN) next_rdata[LIMIT_W-1:0] = limit;
            end
            `LSS_OFF_MGMT_CFG: begin
                next_rdata[`LSS_BIT_HDLC_AUTO] = hdlc_auto;
                next_rdata[`LSS_BIT_ETH_AUTO] = eth_auto;
            end
            `LSS_OFF_VER_CFG: next_rdata[`LSS_BIT_VER_AUTO] = ver_auto;
            `LSS_OFF_IRQ_STAT: next_rdata[2:0] = irq_stat;
            `LSS_OFF_IRQ_MASK: next_rdata[2:0] = irq_mask;
            default: next_rdata = 32'h0000_0000;
        endcase
    end
    // read data register, valid the cycle after rd
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 32'h0000_0000;
        end
    end
    //////////////////////////////////////////////////////////////////
    // reset values and read-back
    a_state_reset: assert property (@(posedge clk)
        !resetn |=> state_code == `LSS_CODE_STANDBY)
        else $error("state not standby after reset");
    a_limit_reset: assert property (@(posedge clk)
        !resetn |=> limit == `LSS_RST_LIMIT && done == `LSS_RST_DONE)
        else $error("limit or done bits not reset");
    a_state_read: assert property (@(posedge clk)
        disable iff (!resetn) rd && addr == `LSS_OFF_STATUS && SM_EN
        |=> rdata[10:8] == $past(code))
        else $error("state field does not track machine");
    a_expired_read: assert property (@(posedge clk)
        disable iff (!resetn) rd && addr == `LSS_OFF_STATUS && SM_EN
        |=> rdata[`LSS_BIT_EXPIRED] == $past(expired))
        else $error("expiry flag not shown in status");
    a_limit_write: assert property (@(posedge clk)
        disable iff (!resetn) wr_tim ##1 rd && addr == `LSS_OFF_TIMER
        |=> rdata[LIMIT_W-1:0] == $past(wdata[LIMIT_W-1:0], 2))
        else $error("timer limit not stored");
    a_reserved_zero: assert property (@(posedge clk)
        disable iff (!resetn) rd && addr == `LSS_OFF_STATUS
        |=> rdata[31:17] == 15'h0000 && rdata[15:11] == 5'h00
        && rdata[7:4] == 4'h0)
        else $error("reserved status bits not zero");
    a_timer_reserved: assert property (@(posedge clk)
        disable iff (!resetn) rd && addr == `LSS_OFF_TIMER
        |=> rdata[31:LIMIT_W] == '0)
        else $error("reserved timer bits not zero");
    a_rdata_idle: assert property (@(posedge clk) disable iff (!resetn)
        !rd |=> rdata == 32'h0000_0000)
        else $error("read data not zero outside a read");
    // done bits set by inputs and by autonegotiation
    a_line_input: assert property (@(posedge clk)
        disable iff (!resetn) SM_EN && line_done_in
        |=> done[`LSS_BIT_LINE_DONE])
        else $error("line done input did not set bit");
    a_ver_input: assert property (@(posedge clk)
        disable iff (!resetn) SM_EN && ver_done_in
        |=> done[`LSS_BIT_VER_DONE])
        else $error("version done input did not set bit");
    a_input_sets: assert property (@(posedge clk)
        disable iff (!resetn) SM_EN && vend_done_in
        |=> done[`LSS_BIT_VEND_DONE])
        else $error("done input did not set bit");
    a_mgmt_auto: assert property (@(posedge clk)
        disable iff (!resetn) SM_EN && mgmt_auto && mgmt_auto_ok
        |=> done[`LSS_BIT_MGMT_DONE])
        else $error("management autoneg did not set done");
    a_ver_set: assert property (@(posedge clk)
        disable iff (!resetn) SM_EN && ver_auto && ver_auto_ok
        |=> done[`LSS_BIT_VER_DONE])
        else $error("version autoneg did not set done");
    a_ver_auto: assert property (@(posedge clk)
        disable iff (!resetn) !(ver_auto && ver_auto_ok) && !ver_done_in
        && !wr_stat && !done[`LSS_BIT_VER_DONE]
        |=> !done[`LSS_BIT_VER_DONE])
        else $error("version done set without cause");
    a_fail_clear: assert property (@(posedge clk)
        disable iff (!resetn) code == `LSS_CODE_PASSIVE
        && $past(code) == `LSS_CODE_MGMT
        |-> !$past(done[`LSS_BIT_MGMT_DONE]))
        else $error("passive entered with management done");
    a_irq_level: assert property (@(posedge clk) disable iff (!resetn)
        |(irq_stat & irq_mask) |=> irq)
        else $error("interrupt not raised");
    a_irq_sticky: assert property (@(posedge clk) disable iff (!resetn)
        !wr_istat |=> (irq_stat & $past(irq_stat)) == $past(irq_stat))
        else $error("interrupt status bit lost without clear");
endmodule // lss_regs

//--- core/lss_timer.sv
`timescale 1ns/1ps
`include "lss_params.svh"
module lss_timer #(
    parameter int WIDTH = 20
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic run,
    input wire logic [WIDTH-1:0] limit,
    output logic expired
);
    import lss_pkg::*;
    logic [WIDTH-1:0] count; // core clock cycles spent running
    logic reached; // count has met the threshold
    assign reached = (count >= limit);
    ////////////////////////////////////////////////////////////////
    // cycle counter, saturating, cleared while idle
    always_ff @(posedge clk) begin
        if (!resetn || !run) begin
            count <= '0;
        end else if (!reached) begin
            count <= count + 1'b1;
        end
    end
    // expiry flag, held until the timer stops
    always_ff @(posedge clk) begin
        if (!resetn || !run) begin
            expired <= 1'b0;
        end else if (reached) begin
            expired <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////
    a_timer_expiry: assert property (@(posedge clk)
        disable iff (!resetn) run && count >= limit |=> expired)
        else $error("timer did not expire at threshold");
    // a limit raised after expiry keeps the flag, so only a fresh rise counts
    a_timer_early: assert property (@(posedge clk)
        disable iff (!resetn) run && $past(run) && !$past(reached)
        && !$past(expired) |-> !expired)
        else $error("timer expired before threshold");
endmodule // lss_timer

//--- verification/lss_far_end.sv
`timescale 1ns/1ps
`include "lss_params.svh"
// far end of the start-up link: remote endpoint plus negotiation logic
module lss_far_end (
    input wire logic clk,
    input wire logic resetn,
    input wire lss_pkg::lss_code_t state_code,
    input wire logic link_up,
    input wire logic quiet,
    input wire logic auto,
    input wire logic slow,
    input wire logic fail_mgmt,
    output logic start,
    output logic link_lost,
    output logic l1_sync_ok,
    output logic line_done_in,
    output logic ver_done_in,
    output logic mgmt_done_in,
    output logic vend_done_in,
    output logic ver_auto_ok,
    output logic mgmt_auto_ok,
    output logic mgmt_auto_fail
);
    import lss_pkg::*;
    lss_code_t last_code; // state seen one cycle ago
    logic [4:0] dwell; // cycles spent in the current state
    logic ready; // answer is due in this state
    logic talk; // done signals allowed at all
    //////////////////////////////////////////////////////////////////
    // prompt or slow answer after entering a state
    // dwell is stale on the first cycle of a new state, so wait for it
    assign ready = resetn && state_code == last_code
        && (dwell >= (slow ? 5'h14 : 5'h02));
    assign talk = ready && !quiet;
    always_ff @(posedge clk) begin
        if (!resetn || state_code != last_code) begin
            dwell <= 5'h00;
        end else if (!ready) begin
            dwell <= dwell + 5'h01;
        end
        last_code <= state_code;
    end
    //////////////////////////////////////////////////////////////////
    // link presence: down forces standby
    assign start = link_up;
    assign link_lost = !link_up;
    //////////////////////////////////////////////////////////////////
    // negotiation answers per state, l1_sync_ok in L1 sync even when quiet, line_done_in there only when not quiet
    always_ff @(posedge clk) begin
        l1_sync_ok <= ready && state_code == `LSS_CODE_L1SYNC;
        line_done_in <= talk && state_code == `LSS_CODE_L1SYNC;
        ver_done_in <= talk && !auto && state_code == `LSS_CODE_PROTO;
        ver_auto_ok <= talk && auto && state_code == `LSS_CODE_PROTO;
        mgmt_done_in <= talk && !auto && !fail_mgmt
            && state_code == `LSS_CODE_MGMT;
        mgmt_auto_ok <= talk && auto && !fail_mgmt
            && state_code == `LSS_CODE_MGMT;
        mgmt_auto_fail <= ready && fail_mgmt && state_code == `LSS_CODE_MGMT;
        vend_done_in <= talk && state_code == `LSS_CODE_IFACE;
    end
endmodule // lss_far_end

//--- verification/tb_lss_regs.sv
`timescale 1ns/1ps
`include "lss_params.svh"
// register and bring-up bench for the start-up sequence block
module tb_lss_regs;
    import lss_pkg::*;
    logic clk, resetn, wr, rd, irq, timer_expired;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic start, link_lost, l1_sync_ok, line_done_in, ver_done_in;
    logic mgmt_done_in, vend_done_in, ver_auto_ok, mgmt_auto_ok;
    logic mgmt_auto_fail, link_up, quiet, auto, slow, fail_mgmt;
    lss_code_t state_code;
    int errors = 0;
    int compares = 0;
    int i;
    //////////////////////////////////////////////////////////////////
    // clock and instances
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    lss_regs u_lss_regs (.clk(clk), .resetn(resetn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
        .start(start), .link_lost(link_lost), .l1_sync_ok(l1_sync_ok),
        .line_done_in(line_done_in), .ver_done_in(ver_done_in),
        .mgmt_done_in(mgmt_done_in), .vend_done_in(vend_done_in),
        .ver_auto_ok(ver_auto_ok), .mgmt_auto_ok(mgmt_auto_ok),
        .mgmt_auto_fail(mgmt_auto_fail), .state_code(state_code),
        .timer_expired(timer_expired));
    lss_far_end u_lss_far_end (.clk(clk), .resetn(resetn),
        .state_code(state_code), .link_up(link_up), .quiet(quiet),
        .auto(auto), .slow(slow), .fail_mgmt(fail_mgmt), .start(start),
        .link_lost(link_lost), .l1_sync_ok(l1_sync_ok),
        .line_done_in(line_done_in), .ver_done_in(ver_done_in),
        .mgmt_done_in(mgmt_done_in), .vend_done_in(vend_done_in),
        .ver_auto_ok(ver_auto_ok), .mgmt_auto_ok(mgmt_auto_ok),
        .mgmt_auto_fail(mgmt_auto_fail));
    //////////////////////////////////////////////////////////////////
    // verdict and comparison
    task automatic final_report();
        if (errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    //////////////////////////////////////////////////////////////////
    // register port cycles
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check($sformatf("reg %h", a), rdata, exp);
    endtask
    //////////////////////////////////////////////////////////////////
    // state helpers and reset
    task automatic wait_code(input lss_code_t code, input int bound);
        for (i = 0; i < bound && state_code !== code; i++) begin
            @(posedge clk);
            #1;
        end
        check("state_code", {29'h0, state_code}, {29'h0, code});
        if (state_code !== code) final_report();
    endtask
    task automatic hold_code(input lss_code_t code, input int n);
        repeat (n) @(posedge clk);
        #1;
        check("state_code held", {29'h0, state_code}, {29'h0, code});
    endtask
    task automatic do_reset();
        @(posedge clk);
        resetn <= 1'b0;
        link_up <= 1'b0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
    endtask
    //////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        resetn = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
        link_up = 1'b0; quiet = 1'b0; auto = 1'b0; slow = 1'b0;
        fail_mgmt = 1'b0;
        do_reset();
        // reset values, reserved bits and unmapped place
        rd_reg(`LSS_OFF_STATUS, 32'h00000000);
        rd_reg(`LSS_OFF_TIMER, 32'h00000000);
        rd_reg(`LSS_OFF_MGMT_CFG, 32'h00001080);
        rd_reg(`LSS_OFF_VER_CFG, 32'h00000000);
        rd_reg(8'h04, 32'h00000000);
        wr_reg(`LSS_OFF_TIMER, 32'hFFFFFFFF);
        rd_reg(`LSS_OFF_TIMER, 32'h000FFFFF);
        wr_reg(`LSS_OFF_STATUS, 32'hFFFFFFFF);
        rd_reg(`LSS_OFF_STATUS, 32'h0000000F);
        wr_reg(`LSS_OFF_STATUS, 32'h00000000);
        rd_reg(`LSS_OFF_STATUS, 32'h00000000);
        wr_reg(`LSS_OFF_MGMT_CFG, 32'h00000000);
        rd_reg(`LSS_OFF_MGMT_CFG, 32'h00000000);
        wr_reg(8'h04, 32'hFFFFFFFF);
        rd_reg(8'h04, 32'h00000000);
        do_reset();
        rd_reg(`LSS_OFF_MGMT_CFG, 32'h00001080);
        // software-driven bring-up, timer expiry and interrupts
        quiet <= 1'b1;
        wr_reg(`LSS_OFF_TIMER, 32'h0000001E);
        link_up <= 1'b1;
        wait_code(`LSS_CODE_L1SYNC, 20);
        for (i = 0; i < 60 && timer_expired !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        check("expiry cycle", 32'(i >= 29 && i <= 33), 32'h1);
        if (timer_expired !== 1'b1) final_report();
        hold_code(`LSS_CODE_PROTO, 8);
        rd_reg(`LSS_OFF_STATUS, 32'h00010300);
        rd_reg(`LSS_OFF_IRQ_STAT, 32'h00000001);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr_reg(`LSS_OFF_IRQ_MASK, 32'h00000001);
        repeat (2) @(posedge clk);
        #1;
        check("irq raised", {31'h0, irq}, 32'h1);
        wr_reg(`LSS_OFF_IRQ_STAT, 32'h00000001);
        repeat (2) @(posedge clk);
        #1;
        check("irq cleared", {31'h0, irq}, 32'h0);
        wr_reg(`LSS_OFF_STATUS, 32'h00000002);
        wait_code(`LSS_CODE_MGMT, 4);
        hold_code(`LSS_CODE_MGMT, 8);
        wr_reg(`LSS_OFF_STATUS, 32'h00000006);
        wait_code(`LSS_CODE_IFACE, 4);
        hold_code(`LSS_CODE_IFACE, 8);
        wr_reg(`LSS_OFF_STATUS, 32'h0000000E);
        wait_code(`LSS_CODE_OPER, 4);
        rd_reg(`LSS_OFF_STATUS, 32'h0000070E);
        rd_reg(`LSS_OFF_IRQ_STAT, 32'h00000002);
        link_up <= 1'b0;
        wait_code(`LSS_CODE_STANDBY, 4);
        // bring-up by the done inputs, slow far end
        do_reset();
        quiet <= 1'b0;
        slow <= 1'b1;
        link_up <= 1'b1;
        wait_code(`LSS_CODE_OPER, 200);
        rd_reg(`LSS_OFF_STATUS, 32'h0000070F);
        // autonegotiation gated by its enables
        do_reset();
        slow <= 1'b0;
        auto <= 1'b1;
        wr_reg(`LSS_OFF_MGMT_CFG, 32'h00000000);
        link_up <= 1'b1;
        wait_code(`LSS_CODE_PROTO, 40);
        hold_code(`LSS_CODE_PROTO, 20);
        wr_reg(`LSS_OFF_VER_CFG, 32'h00000001);
        wait_code(`LSS_CODE_MGMT, 20);
        hold_code(`LSS_CODE_MGMT, 20);
        wr_reg(`LSS_OFF_MGMT_CFG, 32'h00001000);
        wait_code(`LSS_CODE_OPER, 40);
        rd_reg(`LSS_OFF_STATUS, 32'h0000070F);
        // management failure ends in passive link
        do_reset();
        auto <= 1'b0;
        fail_mgmt <= 1'b1;
        link_up <= 1'b1;
        wait_code(`LSS_CODE_PASSIVE, 60);
        hold_code(`LSS_CODE_PASSIVE, 8);
        rd_reg(`LSS_OFF_STATUS, 32'h00010503);
        rd_reg(`LSS_OFF_IRQ_STAT, 32'h00000005);
        final_report();
    end
endmodule // tb_lss_regs
